// ===== rtl/ubc_ctrl.sv
// Purpose: Endpoint buffer bookkeeping, SETUP and IN token handling
// Assumes: Tokens arrive synchronous to ref_clk from a serial engine
// Notes:   Processor reaches all control words over APB
//
// The register offsets and register access over APB were chosen for this implementation.
module ubc_ctrl
    import ubc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire ubc_token_t  token,
    input  wire logic [63:0] setup_data,
    output ubc_reply_t       reply,
    output logic             setup_wr,
    output logic [63:0]      setup_wdata,
    output logic             irq
);

    typedef enum logic [2:0] {S_IDLE, S_DATA, S_ACKW, S_STAT} ubc_state_t;

    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [31:0] buf_ctrl [NUM_EP];
    logic [31:0] ep_ctrl  [NUM_EP];
    logic [NUM_EP-1:0] sel;
    logic [NUM_EP-1:0] done;
    logic [NUM_EP-1:0] svc;
    logic [2:0]  status;
    logic [1:0]  gate;
    logic [2:0]  interrupt_enable_mask;
    ubc_state_t  state;
    logic [3:0]  cur_ep;
    logic        cur_buf;
    logic [15:0] ack_cnt;
    logic        timed_out;

    logic        wr_en;
    logic        rd_en;
    logic        is_iso;
    logic        is_dbl;
    logic        stalled;
    logic [15:0] half;
    logic [9:0]  base;
    logic [9:0]  ofs;
    logic        end_xfer;

    ////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////
    // APB decode, zero wait states
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Selected endpoint attributes
    assign is_iso  = ep_ctrl[token.ep][EPC_TYPE_LSB +: 2] == TYPE_ISO;
    assign is_dbl  = ep_ctrl[token.ep][EPC_DOUBLE_BIT];
    assign half    = (is_dbl && sel[token.ep])
                   ? buf_ctrl[token.ep][HALF_W +: HALF_W]
                   : buf_ctrl[token.ep][0 +: HALF_W];
    assign stalled = buf_ctrl[token.ep][STALL_BIT]
                   && (token.ep != 4'h0 || gate[0]);

    // Second buffer offset: iso uses field, else 64 bytes
    always_comb begin
        ofs = 10'h000;
        if (is_dbl && sel[token.ep]) begin
            if (is_iso) begin
                ofs = 10'h080 << buf_ctrl[token.ep][ISO_OFS_LSB +: 2];
            end else begin
                ofs = 10'h040;
            end
        end
        base = {ep_ctrl[token.ep][EPC_BASE_LSB +: 4], 6'h00} + ofs;
    end

    ////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            if (paddr[11:7] == 5'h01) begin
                prdata <= buf_ctrl[paddr[6:3]];
            end else if (paddr < 12'h040) begin
                prdata <= ep_ctrl[paddr[5:2]];
            end else if (paddr == STATUS_ADDR) begin
                prdata <= {29'h0, status};
            end else if (paddr == GATE_ADDR) begin
                prdata <= {30'h0, gate};
            end else if (paddr == INTERRUPT_ENABLE_MASK_ADDR) begin
                prdata <= {29'h0, interrupt_enable_mask};
            end else if (paddr == DONE_ADDR) begin
                prdata <= {16'h0, done};
            end else if (paddr == SVC_ADDR) begin
                prdata <= {16'h0, svc};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Token state machine
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= S_IDLE;
            cur_ep    <= 4'h0;
            cur_buf   <= 1'b0;
            ack_cnt   <= 16'h0;
            timed_out <= 1'b0;
            reply     <= '0;
        end else begin
            reply.valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    timed_out <= 1'b0;
                    if (token.valid && token.kind == UBC_TOK_SETUP) begin
                        reply.valid <= 1'b1;
                        reply.kind  <= UBC_RSP_ACK;
                    end else if (token.valid && token.kind == UBC_TOK_IN) begin
                        cur_ep  <= token.ep;
                        cur_buf <= is_dbl && sel[token.ep];
                        if (stalled) begin
                            reply.valid <= 1'b1;
                            reply.kind  <= UBC_RSP_STALL;
                        end else if (half[AVAIL0_BIT] && half[FULL0_BIT]) begin
                            reply.valid <= 1'b1;
                            reply.kind  <= UBC_RSP_DATA;
                            reply.pid   <= half[PID0_BIT];
                            reply.len   <= half[9:0];
                            reply.addr  <= base;
                            state       <= is_iso ? S_IDLE : S_ACKW;
                        end else if (!is_iso) begin
                            reply.valid <= 1'b1;
                            reply.kind  <= UBC_RSP_NAK;
                        end
                    end
                end
                S_ACKW: begin
                    ack_cnt <= ack_cnt + 16'h1;
                    if (token.valid && token.kind == UBC_TOK_ACK) begin
                        ack_cnt <= 16'h0;
                        state   <= S_STAT;
                    end else if (ack_cnt == 16'(ACK_WAIT_CYC - 1)) begin
                        ack_cnt   <= 16'h0;
                        timed_out <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                S_STAT: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
    assign end_xfer = state == S_STAT;

    ////////////////////////////////////////////////////////////////////
    // Setup store
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_wr    <= 1'b0;
            setup_wdata <= 64'h0;
        end else begin
            setup_wr    <= state == S_IDLE && token.valid && token.kind == UBC_TOK_SETUP;
            setup_wdata <= setup_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Buffer control words, completion write-back
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_EP; i++) begin
                buf_ctrl[i] <= 32'h0;
                ep_ctrl[i]  <= 32'h0;
            end
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                if (wr_en && paddr == BUF_CTRL_BASE + 12'(i * 8)) begin
                    buf_ctrl[i] <= pwdata;
                end
                if (wr_en && paddr == EP_CTRL_BASE + 12'(i * 4)) begin
                    ep_ctrl[i] <= pwdata;
                end
            end
            if (end_xfer) begin
                if (cur_buf) begin
                    buf_ctrl[cur_ep][31:16] <= buf_ctrl[cur_ep][31:16] & KEEP_MASK;
                end else begin
                    buf_ctrl[cur_ep][15:0] <= buf_ctrl[cur_ep][15:0] & KEEP_MASK;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Buffer select per endpoint
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel <= '0;
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                if (buf_ctrl[i][RSTSEL_BIT]) begin
                    sel[i] <= 1'b0;
                end else if (end_xfer && cur_ep == 4'(i)
                             && ep_ctrl[i][EPC_DOUBLE_BIT]) begin
                    sel[i] <= ~sel[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status, gates, done flags; set wins over write-one-clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= 3'h0;
            gate   <= 2'h0;
            interrupt_enable_mask   <= 3'h0;
            done   <= '0;
            svc    <= '0;
        end else begin
            if (wr_en && paddr == INTERRUPT_ENABLE_MASK_ADDR) begin
                interrupt_enable_mask <= pwdata[2:0];
            end
            if (state == S_IDLE && token.valid && token.kind == UBC_TOK_SETUP) begin
                gate <= 2'h0;
            end else if (wr_en && paddr == GATE_ADDR) begin
                gate <= pwdata[1:0];
            end
            status <= (status & ~((wr_en && paddr == STATUS_ADDR) ? pwdata[2:0] : 3'h0))
                    | {timed_out,
                       end_xfer && (cur_buf ? buf_ctrl[cur_ep][LAST1_BIT]
                                            : buf_ctrl[cur_ep][LAST0_BIT]),
                       setup_wr};
            done <= (done & ~((wr_en && paddr == DONE_ADDR) ? pwdata[15:0] : 16'h0))
                  | (end_xfer ? 16'(1) << cur_ep : 16'h0);
            if (end_xfer) begin
                svc[cur_ep] <= cur_buf;
            end
        end
    end

    assign irq = |(status & interrupt_enable_mask);

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_setup_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == S_IDLE && token.valid && token.kind == UBC_TOK_SETUP)
        |=> reply.valid && reply.kind == UBC_RSP_ACK)
        else $error("setup not acked");
    a_setup_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setup_wr |=> status[ST_SETUP_BIT] && gate == 2'h0)
        else $error("setup flag missing");
    a_stall_reply: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == S_IDLE && token.valid && token.kind == UBC_TOK_IN && stalled)
        |=> reply.kind == UBC_RSP_STALL && state == S_IDLE)
        else $error("stall not sent");
    a_ep0_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (token.ep == 4'h0 && !gate[0]) |-> !stalled)
        else $error("ep0 stall ungated");
    a_ack_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(state == S_ACKW) |-> ##[1:300] state != S_ACKW)
        else $error("ack wait unbounded");
    a_done_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        end_xfer |=> done[cur_ep] && !buf_ctrl[$past(cur_ep)][AVAIL0_BIT + 16 * $past(cur_buf)])
        else $error("done not set");
    a_rewrite: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (end_xfer && !cur_buf) |=> buf_ctrl[$past(cur_ep)][FULL0_BIT] == 1'b0)
        else $error("half not rewritten");
    a_sel_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        buf_ctrl[cur_ep][RSTSEL_BIT] |=> !sel[$past(cur_ep)])
        else $error("select not reset");

    // ACK taken, one status cycle, then idle
    sequence s_ack_taken;
        state == S_ACKW && token.valid && token.kind == UBC_TOK_ACK;
    endsequence
    sequence s_status_step;
        end_xfer ##1 (state == S_IDLE);
    endsequence
    a_ack_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_ack_taken |=> s_status_step)
        else $error("ack not completed");

endmodule : ubc_ctrl

// ===== common/ubc_pkg.sv
// Purpose: Constants and types for the endpoint buffer controller
// Assumes: APB slave, one clock, 16 endpoints
// Notes:   Buffer control word layout and map offsets
//
// Functional notes
// - Single buffered uses only low half
// - Hidden buffer select starts 0, alternates on each acknowledged non-iso double-buffered completion
// - Bit 12 resets select, cleared at end
// - Host periodic failures still set full
// - Full: controller clears after emptying a non-iso IN
// - Available cleared after non-iso buffer used
// - Bits 14/30 mark last buffer
// - Bits 13/29 hold data toggle
// - Bits 28:27 pick iso second offset
// - Lengths at 9:0 and 25:16
// - Bit 11 requests STALL in device mode
// - SETUP always accepted, stored at 0, ACK; code accepts it in S_IDLE only
// - EP0 stall needs gate bit; SETUP clears gates
// - SETUP sets received flag, optional interrupt
// - Stalled IN token answers STALL, idle
// - Available and full sends data, else NAK unless iso
// - Non-iso waits ACK, timeout flags error
// - Last buffer sets transfer complete; each acknowledged non-iso double-buffered completion toggles select unless bit 12 is set
// - Buffer done flag and service select
// - Completion rewrites half keeping len,pid,last
package ubc_pkg;

    localparam int          NUM_EP        = 16;
    localparam logic [11:0] BUF_CTRL_BASE = 12'h080;
    localparam logic [11:0] EP_CTRL_BASE  = 12'h000;
    localparam logic [11:0] STATUS_ADDR   = 12'h200;
    localparam logic [11:0] GATE_ADDR     = 12'h204;
    localparam logic [11:0] INTERRUPT_ENABLE_MASK_ADDR     = 12'h208;
    localparam logic [11:0] DONE_ADDR     = 12'h20c;
    localparam logic [11:0] SVC_ADDR      = 12'h210;

    localparam int FULL1_BIT  = 31;
    localparam int LAST1_BIT  = 30;
    localparam int PID1_BIT   = 29;
    localparam int AVAIL1_BIT = 26;
    localparam int LEN1_LSB   = 16;
    localparam int FULL0_BIT  = 15;
    localparam int LAST0_BIT  = 14;
    localparam int PID0_BIT   = 13;
    localparam int RSTSEL_BIT = 12;
    localparam int STALL_BIT  = 11;
    localparam int AVAIL0_BIT = 10;
    localparam int ISO_OFS_LSB = 27;
    localparam int HALF_W     = 16;
    localparam logic [15:0] KEEP_MASK = 16'h63ff;

    localparam int EPC_DOUBLE_BIT = 30;
    localparam int EPC_TYPE_LSB   = 26;
    localparam int EPC_BASE_LSB   = 6;
    localparam logic [1:0] TYPE_ISO = 2'h1;

    localparam int ST_SETUP_BIT    = 0;
    localparam int ST_COMPLETE_BIT = 1;
    localparam int ST_TIMEOUT_BIT  = 2;

    localparam int    CLK_MHZ      = 125;
    localparam int    ACK_WAIT_NS  = 2000;
    localparam int    ACK_WAIT_CYC = ACK_WAIT_NS * CLK_MHZ / 1000;

    typedef enum logic [1:0] {
        UBC_TOK_NONE,
        UBC_TOK_SETUP,
        UBC_TOK_IN,
        UBC_TOK_ACK
    } ubc_tok_t;

    typedef enum logic [1:0] {
        UBC_RSP_ACK,
        UBC_RSP_NAK,
        UBC_RSP_STALL,
        UBC_RSP_DATA
    } ubc_rsp_t;

    typedef struct packed {
        logic       valid;
        ubc_tok_t   kind;
        logic [3:0] ep;
    } ubc_token_t;

    typedef struct packed {
        logic       valid;
        ubc_rsp_t   kind;
        logic       pid;
        logic [9:0] len;
        logic [9:0] addr;
    } ubc_reply_t;

endpackage : ubc_pkg

// ===== verification/ubc_host_model.sv
// Purpose: Bus host model issuing SETUP, IN and ACK tokens
// Assumes: One token per call, one-cycle valid pulse
// Notes:   Lines show inverted values once a token is gone
module ubc_host_model
    import ubc_pkg::*;
(
    input  wire logic   ref_clk,
    output ubc_token_t  token,
    output logic [63:0] setup_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        token      = '0;
        setup_data = '0;
    end

    task automatic send(input ubc_tok_t k, input logic [3:0] e, input logic [63:0] d);
        @(posedge ref_clk);
        token      <= '{valid: 1'b1, kind: k, ep: e};
        setup_data <= d;
        @(posedge ref_clk);
        token      <= '{valid: 1'b0, kind: UBC_TOK_NONE, ep: ~e};
        setup_data <= ~d;
    endtask : send
endmodule : ubc_host_model

// ===== verification/usb_endpoint_buffer_ctrl_setup_in_tb_top.sv
// Purpose: Self-checking bench for the endpoint buffer controller
// Assumes: APB master in bench, host model on token side
// Notes:   Replies checked against a queue of expected notes
module usb_endpoint_buffer_ctrl_setup_in_tb_top;
    import ubc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr   = '0;
    logic [31:0] pwdata  = '0, prdata, rd, w;
    logic        pready, pslverr, setup_wr, irq;
    ubc_token_t  token;
    ubc_reply_t  reply;
    logic [63:0] setup_data, setup_wdata, exp_setup;
    logic [12:0] exp_q[$];
    logic [9:0]  l0, l1, exp_addr;
    logic        p0, p1;
    int          mismatches = 0, n_tests = 0, cycles = 0, seed = 60085;

    always #4 ref_clk = ~ref_clk;

    ubc_host_model host (.ref_clk(ref_clk), .token(token), .setup_data(setup_data));

    ubc_ctrl DUT (
        .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .token(token), .setup_data(setup_data), .reply(reply),
        .setup_wr(setup_wr), .setup_wdata(setup_wdata), .irq(irq)
    );

    task automatic finish_test();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd      = prdata;
        check({pready, pslverr}, 2'b10, "apb response");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        check(rd, e, m);
    endtask : rchk

    // Expected reply noted before the token goes out
    task automatic tk(input ubc_tok_t k, input logic [3:0] e, input logic r,
                      input logic [12:0] x);
        if (r)
            exp_q.push_back(x);
        exp_setup = {$random(seed), $random(seed)};
        host.send(k, e, exp_setup);
        repeat (3) @(posedge ref_clk);
    endtask : tk

    always @(posedge ref_clk) begin
        logic [12:0] g, e;
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            finish_test();
        end
        if (reply.valid === 1'b1) begin
            g = {reply.kind, reply.pid, reply.len};
            e = exp_q.size() ? exp_q.pop_front() : ~g;
            if (e[12:11] != UBC_RSP_DATA)
                g[10:0] = e[10:0];
            check(g, e, "reply");
            if (e[12:11] == UBC_RSP_DATA)
                check(reply.addr, exp_addr, "buffer address");
        end
        if (setup_wr === 1'b1)
            check(setup_wdata, exp_setup, "setup store");
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        apb(1'b1, 12'hffc, $random(seed));
        rchk(12'hffc, 32'h0, "unmapped");
        w = $random(seed);
        apb(1'b1, BUF_CTRL_BASE + 12'h028, w);
        rchk(BUF_CTRL_BASE + 12'h028, w, "buf readback");
        // SETUP clears gates, sets flag, raises interrupt
        apb(1'b1, GATE_ADDR, 32'h3);
        apb(1'b1, INTERRUPT_ENABLE_MASK_ADDR, 32'h1);
        tk(UBC_TOK_SETUP, 4'h0, 1'b1, {UBC_RSP_ACK, 11'h0});
        check(irq, 1'b1, "irq on setup");
        rchk(STATUS_ADDR, 32'h1, "setup flag");
        rchk(GATE_ADDR, 32'h0, "gate cleared");
        apb(1'b1, STATUS_ADDR, 32'h7);
        @(posedge ref_clk);
        check(irq, 1'b0, "irq cleared");
        // EP0 stall gated
        apb(1'b1, BUF_CTRL_BASE, 32'h1 << STALL_BIT);
        tk(UBC_TOK_IN, 4'h0, 1'b1, {UBC_RSP_NAK, 11'h0});
        apb(1'b1, GATE_ADDR, 32'h3);
        tk(UBC_TOK_IN, 4'h0, 1'b1, {UBC_RSP_STALL, 11'h0});
        tk(UBC_TOK_SETUP, 4'h0, 1'b1, {UBC_RSP_ACK, 11'h0});
        tk(UBC_TOK_IN, 4'h0, 1'b1, {UBC_RSP_NAK, 11'h0});
        apb(1'b1, EP_CTRL_BASE + 12'h010, 32'h8800_0400);
        apb(1'b1, BUF_CTRL_BASE + 12'h020, 32'h1 << STALL_BIT);
        tk(UBC_TOK_IN, 4'h4, 1'b1, {UBC_RSP_STALL, 11'h0});
        // Single buffered IN, slow ACK
        apb(1'b1, STATUS_ADDR, 32'h7);
        apb(1'b1, EP_CTRL_BASE + 12'h004, 32'h8800_0180);
        l0 = 10'($random(seed));
        p0 = 1'($random(seed));
        exp_addr = 10'h180;
        w  = {16'($random(seed)), 1'b1, 1'b1, p0, 3'h0, l0};
        apb(1'b1, BUF_CTRL_BASE + 12'h008, w);
        apb(1'b1, BUF_CTRL_BASE + 12'h008, w | 32'h400);
        tk(UBC_TOK_IN, 4'h1, 1'b1, {UBC_RSP_DATA, p0, l0});
        repeat (100) @(posedge ref_clk);
        tk(UBC_TOK_ACK, 4'h1, 1'b0, 13'h0);
        rchk(BUF_CTRL_BASE + 12'h008, {w[31:16], 2'b01, p0, 3'h0, l0}, "rewrite");
        rchk(STATUS_ADDR, 32'h2, "complete");
        rchk(DONE_ADDR, 32'h2, "buf done");
        apb(1'b1, STATUS_ADDR, 32'h7);
        apb(1'b1, DONE_ADDR, 32'hffff_ffff);
        // No ACK: timeout, word untouched
        apb(1'b1, BUF_CTRL_BASE + 12'h008, w | 32'h400);
        tk(UBC_TOK_IN, 4'h1, 1'b1, {UBC_RSP_DATA, p0, l0});
        repeat (260) @(posedge ref_clk);
        rchk(STATUS_ADDR, 32'h4, "timeout");
        rchk(BUF_CTRL_BASE + 12'h008, w | 32'h400, "no update");
        // Double buffered select, reset select bit
        apb(1'b1, EP_CTRL_BASE + 12'h008, 32'hc800_0200);
        {l1, p1} = 11'($random(seed));
        w = {2'b11, p1, 2'b00, 1'b1, l1, 2'b10, p0, 3'b001, l0};
        for (int i = 0; i < 4; i++) begin
            if (i != 1)
                apb(1'b1, BUF_CTRL_BASE + 12'h010, w | (32'(i == 3) << RSTSEL_BIT));
            exp_addr = (i == 1) ? 10'h240 : 10'h200;
            tk(UBC_TOK_IN, 4'h2, 1'b1,
               (i == 1) ? {UBC_RSP_DATA, p1, l1} : {UBC_RSP_DATA, p0, l0});
            tk(UBC_TOK_ACK, 4'h2, 1'b0, 13'h0);
            if (i == 1)
                rchk(BUF_CTRL_BASE + 12'h010, {2'b01, p1, 3'h0, l1, 2'b00, p0, 3'h0, l0},
                     "both halves");
        end
        rchk(BUF_CTRL_BASE + 12'h010, {w[31:16], 2'b00, p0, 3'h0, l0}, "select reset");
        // Isochronous: no NAK, no ACK wait
        apb(1'b1, EP_CTRL_BASE + 12'h00c, 32'h8400_0300);
        tk(UBC_TOK_IN, 4'h3, 1'b0, 13'h0);
        apb(1'b1, BUF_CTRL_BASE + 12'h018, {16'h0, 2'b10, p0, 3'b001, l0});
        exp_addr = 10'h300;
        tk(UBC_TOK_IN, 4'h3, 1'b1, {UBC_RSP_DATA, p0, l0});
        apb(1'b1, BUF_CTRL_BASE + 12'h008, 32'h0);
        tk(UBC_TOK_IN, 4'h1, 1'b1, {UBC_RSP_NAK, 11'h0});
        check(exp_q.size(), 0, "missing reply");
        finish_test();
    end
endmodule : usb_endpoint_buffer_ctrl_setup_in_tb_top
